// >>> core/fpic_pkg.sv
// Shared constants and types for the flag polarity and interrupt combiner
package fpic_pkg;

  // Register offsets on the common page
  localparam logic [9:0] FPIC_OFF_FLAG_INV  = 10'h1c2;
  localparam logic [9:0] FPIC_OFF_IRQ_CAUSE = 10'h1d4;

  // Widths and reset values
  localparam int          FPIC_REG_W        = 16;
  localparam int          FPIC_PIN_FLAGS    = 13;
  localparam int          FPIC_SRC_W        = 13;
  localparam logic [15:0] FPIC_INV_RST      = 16'h0000;
  localparam logic [15:0] FPIC_CAUSE_RST    = 16'h0000;

  // Trigger pin positions inside the inversion register
  localparam int          FPIC_TRIG_LO      = 3;
  localparam int          FPIC_TRIG_HI      = 8;

  // Cause register field positions
  localparam int          FPIC_B_HALT       = 0;
  localparam int          FPIC_B_SWREQ      = 4;
  localparam int          FPIC_B_DRV        = 8;
  localparam int          FPIC_B_SERIAL     = 9;
  localparam int          FPIC_B_CLKLOSS    = 10;
  localparam int          FPIC_B_SUM1       = 11;
  localparam int          FPIC_B_SUM2       = 12;

  // Register write and read strobes from the serial front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } fpic_reg_req_t;

  // Interrupt sources, already gated by their own enables except clk_loss, which fpic_top gates with i_clk_loss_en
  typedef struct packed {
    logic       code_sum_bad_lane2;
    logic       code_sum_bad_lane1;
    logic       clk_loss;
    logic       serial_err;
    logic       drv_off;
    logic [3:0] sw_request;
    logic [3:0] diag_stop;
  } fpic_src_t;

  // Combiner state
  typedef enum logic [0:0] {
    FPIC_IDLE = 1'b0,
    FPIC_HELD = 1'b1
  } fpic_state_t;

endpackage

// >>> core/fpic_flag_pol.sv
// Per-flag polarity stage between device pins and the flag bus
`timescale 1ns/1ps
`default_nettype none
module fpic_flag_pol #(
  parameter int N = 13
) (
  // Configuration
  input  wire logic [N-1:0] i_inv,
  input  wire logic [N-1:0] i_src,
  input  wire logic [N-1:0] i_dir,
  // Data
  input  wire logic [N-1:0] i_pin,
  input  wire logic [N-1:0] i_int,
  output logic      [N-1:0] o_bus,
  output logic      [N-1:0] o_pin,
  output logic      [N-1:0] o_pin_oe
);
  initial begin
    if (N < 1 || N > 16) $error("fpic_flag_pol: N out of range");
  end

  // One polarity cell per pin-routed flag
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_cell
      wire logic use_in  = i_src[g] & i_dir[g];
      wire logic use_out = i_src[g] & ~i_dir[g];
      // Inversion only when a pin is involved
      assign o_bus[g]    = use_in ? (i_pin[g] ^ i_inv[g]) : i_int[g];
      assign o_pin[g]    = use_out & (i_int[g] ^ i_inv[g]);
      assign o_pin_oe[g] = use_out;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> core/fpic_sync.sv
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module fpic_sync #(
  parameter int W = 13
) (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_sys_rst,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  initial begin
    if (W < 1) $error("fpic_sync: W must be positive");
  end

  // First stage feeds only the second
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end
  assign o_q = sync_ff;
endmodule
`default_nettype wire

// >>> core/fpic_top.sv
// Flag polarity register and interrupt combiner for the common page
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - Inversion bits 12..0 invert flag per pin; bits 15..13 reserved; reset zero.
// - Inversion applies only to flags routed to a device pin.
// - Unrouted trigger pins use bits 8..3 as polarity; 1 is active low.
// - Interrupt pin is low while any enabled source requests.
// - Cause register captures all source states when pin asserts.
// - Cause register frozen while pin stays asserted.
// - No request: pin released high and cause register cleared.
// - Cause register readable over serial link; host reads it.
// - Four microcore software requests are interrupt sources.
// - Driver disable is an interrupt source.
// - Serial communication error is an interrupt source.
// - Reference clock loss is an interrupt source.
// - Wrong code signature of either lane is a source.
// - Bits 0..3 hold diagnosis halts for four microcores.
// - Bits 4..7 hold the four microcore software requests.
// - Bit 8 driver disabled, bit 9 serial error.
// - Bit 10 clock missing, bits 11,12 code sums; 15..13 reserved.
// - Source 1 with direction 1 is input; direction 0 output.
// - Clock loss request stays until backup clock register read.
module fpic_top #(
  parameter int N_FLAGS = fpic_pkg::FPIC_PIN_FLAGS
) (
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_sys_rst,
  // Register access from serial front end
  input  wire fpic_pkg::fpic_reg_req_t i_req,
  output logic [15:0]                o_rdata,
  output logic                       o_rvalid,
  // Flag routing configuration
  input  wire logic [N_FLAGS-1:0]    i_flag_src,
  input  wire logic [N_FLAGS-1:0]    i_flag_dir,
  // Flag pins and buses
  input  wire logic [N_FLAGS-1:0]    i_flag_pin,
  input  wire logic [N_FLAGS-1:0]    i_int_flags,
  output logic      [N_FLAGS-1:0]    o_flag_bus,
  output logic      [N_FLAGS-1:0]    o_flag_pin,
  output logic      [N_FLAGS-1:0]    o_flag_pin_oe,
  // Trigger pins after polarity, active high
  output logic      [5:0]            o_trigger_active,
  // Interrupt sources
  input  wire fpic_pkg::fpic_src_t   i_src,
  input  wire logic                  i_clk_loss_en,
  input  wire logic                  i_clk_status_rd,
  // Interrupt pin toward host
  output logic                       o_host_request_n
);
  localparam int TL = fpic_pkg::FPIC_TRIG_LO;
  localparam int TH = fpic_pkg::FPIC_TRIG_HI;

  initial begin
    if (N_FLAGS != fpic_pkg::FPIC_PIN_FLAGS)
      $error("fpic_top: N_FLAGS must be 13");
  end

  // Registers
  logic [15:0]           flag_inv_ff;
  logic [15:0]           cause_ff;
  logic                  clk_loss_ff;
  fpic_pkg::fpic_state_t state_ff;
  logic                  req_n_ff;
  logic [15:0]           rdata_ff;
  logic                  rvalid_ff;
  logic [N_FLAGS-1:0]    bus_ff;
  logic [N_FLAGS-1:0]    pin_ff;
  logic [N_FLAGS-1:0]    pin_oe_ff;
  logic [5:0]            trig_ff;

  // Synchronised pins
  logic [N_FLAGS-1:0]    pin_sync;
  logic [N_FLAGS-1:0]    bus_c;
  logic [N_FLAGS-1:0]    pin_c;
  logic [N_FLAGS-1:0]    pin_oe_c;

  fpic_sync #(.W(N_FLAGS)) u_sync (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_d        (i_flag_pin),
    .o_q        (pin_sync)
  );

  fpic_flag_pol #(.N(N_FLAGS)) u_pol (
    .i_inv    (flag_inv_ff[N_FLAGS-1:0]),
    .i_src    (i_flag_src),
    .i_dir    (i_flag_dir),
    .i_pin    (pin_sync),
    .i_int    (i_int_flags),
    .o_bus    (bus_c),
    .o_pin    (pin_c),
    .o_pin_oe (pin_oe_c)
  );

  // Address decode
  wire logic hit_inv   = (i_req.addr == fpic_pkg::FPIC_OFF_FLAG_INV);
  wire logic hit_cause = (i_req.addr == fpic_pkg::FPIC_OFF_IRQ_CAUSE);
  wire logic wr_inv    = i_req.wr & hit_inv;
  wire logic [15:0] nxt_flag_inv =
    {3'h0, i_req.wdata[12:0]};

  // Trigger polarity for pins not routed as flags
  wire logic [5:0] trig_raw = pin_sync[TH:TL];
  wire logic [5:0] trig_pol = flag_inv_ff[TH:TL];
  wire logic [5:0] nxt_trig =
    (trig_raw ^ trig_pol) & ~i_flag_src[TH:TL];

  // Clock loss request held until status register read
  wire logic nxt_clk_loss =
    i_clk_loss_en & (i_src.clk_loss |
    (clk_loss_ff & ~i_clk_status_rd));

  // Live request vector in cause register layout
  wire logic [15:0] live = {3'h0,
    i_src.code_sum_bad_lane2,
    i_src.code_sum_bad_lane1,
    clk_loss_ff,
    i_src.serial_err,
    i_src.drv_off,
    i_src.sw_request,
    i_src.diag_stop};
  wire logic any_req = |live;

  // Next cause register: capture on assert, hold, clear on release
  wire logic [15:0] nxt_cause =
    (state_ff == fpic_pkg::FPIC_IDLE) ?
      (any_req ? live : fpic_pkg::FPIC_CAUSE_RST) :
      (any_req ? cause_ff : fpic_pkg::FPIC_CAUSE_RST);
  wire fpic_pkg::fpic_state_t nxt_state =
    any_req ? fpic_pkg::FPIC_HELD : fpic_pkg::FPIC_IDLE;

  // Read mux
  wire logic [15:0] nxt_rdata =
    hit_inv   ? flag_inv_ff :
    hit_cause ? cause_ff    : 16'h0000;

  // Configuration register
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      flag_inv_ff <= fpic_pkg::FPIC_INV_RST;
    end else if (wr_inv) begin
      flag_inv_ff <= nxt_flag_inv;
    end
  end

  // Combiner; writes to the cause register are not decoded
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cause_ff    <= fpic_pkg::FPIC_CAUSE_RST;
      state_ff    <= fpic_pkg::FPIC_IDLE;
      req_n_ff    <= 1'b1;
      clk_loss_ff <= 1'b0;
    end else begin
      cause_ff    <= nxt_cause;
      state_ff    <= nxt_state;
      req_n_ff    <= ~any_req;
      clk_loss_ff <= nxt_clk_loss;
    end
  end

  // Read data and flag outputs
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
      bus_ff    <= '0;
      pin_ff    <= '0;
      pin_oe_ff <= '0;
      trig_ff   <= 6'h00;
    end else begin
      rdata_ff  <= i_req.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= i_req.rd;
      bus_ff    <= bus_c;
      pin_ff    <= pin_c;
      pin_oe_ff <= pin_oe_c;
      trig_ff   <= nxt_trig;
    end
  end

  assign o_rdata          = rdata_ff;
  assign o_rvalid         = rvalid_ff;
  assign o_flag_bus       = bus_ff;
  assign o_flag_pin       = pin_ff;
  assign o_flag_pin_oe    = pin_oe_ff;
  assign o_trigger_active = trig_ff;
  assign o_host_request_n = req_n_ff;

  // Assertions
  property p_pin_low;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      any_req |=> !o_host_request_n;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("request pin not low on request");

  property p_capture;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (state_ff == fpic_pkg::FPIC_IDLE && any_req) |=> cause_ff == $past(live);
  endproperty
  a_capture: assert property (p_capture)
    else $error("cause not captured on assertion");

  property p_frozen;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!o_host_request_n && any_req) |=> $stable(cause_ff);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("cause changed while pin asserted");

  property p_release;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      !any_req |=> (o_host_request_n && cause_ff == 16'h0000);
  endproperty
  a_release: assert property (p_release)
    else $error("pin or cause not released");

  property p_read;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (i_req.rd && hit_cause) |=> (o_rvalid && o_rdata == $past(cause_ff));
  endproperty
  a_read: assert property (p_read)
    else $error("cause read data wrong");

  property p_reserved;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      flag_inv_ff[15:13] == 3'h0 && cause_ff[15:13] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits set");

  property p_clk_hold;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (clk_loss_ff && i_clk_loss_en && !i_clk_status_rd) |=> clk_loss_ff;
  endproperty
  a_clk_hold: assert property (p_clk_hold)
    else $error("clock loss request dropped before read");

  property p_trig;
    @(posedge i_core_clk) disable iff (i_sys_rst)
      (!i_flag_src[TL] && flag_inv_ff[TL] && !pin_sync[TL])
        |=> o_trigger_active[0];
  endproperty
  a_trig: assert property (p_trig)
    else $error("active low trigger not seen");

  c_assert:  cover property (@(posedge i_core_clk) $fell(o_host_request_n));
  c_release: cover property (@(posedge i_core_clk) $rose(o_host_request_n));
  c_read:    cover property (@(posedge i_core_clk) i_req.rd && hit_cause);
endmodule
`default_nettype wire

// >>> testbench/fpic_host_model.sv
// Host controller model: register accesses over the serial front end
`timescale 1ns/1ps
`default_nettype none
module fpic_host_model (
  // Clock
  input  wire logic                 i_core_clk,
  // Device answers
  input  wire logic [15:0]          i_rdata,
  input  wire logic                 i_rvalid,
  // Requests toward the device
  output var fpic_pkg::fpic_reg_req_t o_req
);
  // Bus idles with no strobe
  initial o_req = '0;

  // Write: one-cycle strobe launched at the falling edge
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_core_clk);
    o_req.wr = 1'b0;
  endtask

  // Read: data taken with the valid pulse, marker if it never came
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(negedge i_core_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(negedge i_core_clk);
    o_req.rd = 1'b0;
    d = (i_rvalid === 1'b1) ? i_rdata : 16'hdead;
  endtask
endmodule
`default_nettype wire

// >>> testbench/test_flag_polarity_irq_combiner.sv
// Self-checking bench for the flag polarity and interrupt combiner
`timescale 1ns/1ps
`default_nettype none
module test_flag_polarity_irq_combiner;
  logic                    clk, rst, rvalid, irq_n, ld_en, st_rd;
  logic [15:0]             rdata, v, lf;
  logic [12:0]             src, dir, pin, intf, bus, po, poe, p, in_m;
  logic [5:0]              trg;
  fpic_pkg::fpic_reg_req_t req;
  fpic_pkg::fpic_src_t     s;
  int                      failures, compares;

  // Device under test and host model
  fpic_top u_fpic_top (
    .i_core_clk(clk), .i_sys_rst(rst), .i_req(req), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_flag_src(src), .i_flag_dir(dir),
    .i_flag_pin(pin), .i_int_flags(intf), .o_flag_bus(bus),
    .o_flag_pin(po), .o_flag_pin_oe(poe), .o_trigger_active(trg),
    .i_src(s), .i_clk_loss_en(ld_en), .i_clk_status_rd(st_rd),
    .o_host_request_n(irq_n));
  fpic_host_model u_fpic_host_model (
    .i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  // Next value of the stimulus shift register
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Comparison with mismatch report
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bounded wait for the interrupt pin level
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (irq_n !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 8) begin
        chk("irq_wait", {15'h0, lvl}, {15'h0, irq_n});
        finish_test();
      end
    end
  endtask

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    {src, dir, pin, intf, s} = '0;
    {ld_en, st_rd} = 2'b00;
    failures = 0;
    compares = 0;
    lf = 16'hdc57;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // Reset values, read-only cause, unmapped address
    chk("pin_rst", 16'h0001, {15'h0, irq_n});
    u_fpic_host_model.rd(fpic_pkg::FPIC_OFF_FLAG_INV, v);
    chk("inv_rst", fpic_pkg::FPIC_INV_RST, v);
    u_fpic_host_model.wr(fpic_pkg::FPIC_OFF_IRQ_CAUSE, 16'hffff);
    u_fpic_host_model.rd(fpic_pkg::FPIC_OFF_IRQ_CAUSE, v);
    chk("cause_rst", fpic_pkg::FPIC_CAUSE_RST, v);
    u_fpic_host_model.rd(10'h3ff, v);
    chk("unmapped", 16'h0000, v);
    $display("test registers done");
    // Flag polarity: first pass all internal, then random routing
    for (int i = 0; i < 10; i++) begin
      lf = nxt(lf);
      u_fpic_host_model.wr(fpic_pkg::FPIC_OFF_FLAG_INV, lf);
      u_fpic_host_model.rd(fpic_pkg::FPIC_OFF_FLAG_INV, v);
      chk("inv_reg", {3'h0, lf[12:0]}, v);
      src = (i == 0) ? 13'h0000 : nxt(lf + 16'h1)[12:0];
      dir = nxt(lf + 16'h2)[12:0];
      pin = nxt(lf + 16'h3)[12:0];
      intf = nxt(lf + 16'h4)[12:0];
      repeat (4) @(negedge clk);
      in_m = src & dir;
      chk("flag_bus", {3'h0, (in_m & (pin ^ lf[12:0])) | (~in_m & intf)},
          {3'h0, bus});
      chk("pin_oe", {3'h0, src & ~dir}, {3'h0, poe});
      chk("pin_out", {3'h0, (intf ^ lf[12:0]) & src & ~dir},
          {3'h0, po & poe});
      chk("trigger", {10'h0, (pin[8:3] ^ lf[8:3]) & ~src[8:3]},
          {10'h0, trg});
    end
    $display("test flags done");
    // Each source alone, then random mixes without clock loss
    ld_en = 1'b1;
    for (int k = 0; k < 18; k++) begin
      lf = nxt(lf);
      p = (k < 13) ? 13'h0001 << k : (lf[12:0] & 13'h1bff) | 13'h0001;
      s = fpic_pkg::fpic_src_t'(p);
      wait_pin(1'b0);
      u_fpic_host_model.rd(fpic_pkg::FPIC_OFF_IRQ_CAUSE, v);
      chk("cause_set", {3'h0, p}, v);
      s = fpic_pkg::fpic_src_t'(13'h1fff);
      u_fpic_host_model.wr(fpic_pkg::FPIC_OFF_IRQ_CAUSE, 16'h0000);
      u_fpic_host_model.rd(fpic_pkg::FPIC_OFF_IRQ_CAUSE, v);
      chk("cause_held", {3'h0, p}, v);
      s = '0;
      repeat (3) @(negedge clk);
      chk("pin_clk_hold", 16'h0000, {15'h0, irq_n});
      st_rd = 1'b1;
      @(negedge clk);
      st_rd = 1'b0;
      wait_pin(1'b1);
      u_fpic_host_model.rd(fpic_pkg::FPIC_OFF_IRQ_CAUSE, v);
      chk("cause_clr", 16'h0000, v);
    end
    $display("test interrupts done");
    // Clock loss with its host enable off raises nothing
    ld_en = 1'b0;
    s = fpic_pkg::fpic_src_t'(13'h0400);
    repeat (4) @(negedge clk);
    chk("clk_loss_off", 16'h0001, {15'h0, irq_n});
    s = '0;
    $display("test clock loss enable done");
    finish_test();
  end
endmodule
`default_nettype wire
